//--- verilog/dpwm_timer.sv
// dual 8-bit pwm timer with apb register slave
// assumes one 20 mhz bus clock, synchronous active-high reset
//
// Function
// R01 - two channels, each with 8-bit counter, period, duty and own output pin
// R02 - duty spans from never asserted to asserted for whole period
// R03 - concat joins channels to 16 bits, output bit 1, clock by channel 2 select
// R04 - period and duty buffered, applied at rollover or while disabled
// R05 - writing the counter after period or duty applies new values at once
// R06 - three-bit prescale code divides bus clock by one up to 128
// R07 - scaled clock is prescaled clock over scale value over two, zero means 256
// R08 - per-channel clock select picks prescaled or scaled clock
// R09 - polarity bit sets start level, output flips when count reaches duty
// R10 - polarity and clock-select register writable any time
// R11 - one enable bit per channel, both clear after reset
// R12 - unimplemented bits of enable, polarity, prescale registers read zero
// R13 - enable register holds two test bits, clear after reset, unused
// R14 - any counter write clears that counter to zero
// R15 - counter restarts at period end and latches buffered period and duty
// R16 - boundary duty or period values give a constant output level
// R17 - disabled channel holds counter zero and output at start level
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "dpwm_defines.svh"

module dpwm_timer (
    input  wire logic                   i_clk,
    input  wire logic                   i_reset,
    input  wire dpwm_pkg::dpwm_apb_req_t i_apb,
    output logic [31:0]                 o_prdata,
    output logic                        o_pready,
    output logic                        o_pslverr,
    output logic [1:0]                  o_pwm
);

    // decode a byte address into a register selector
    // misaligned or unmapped addresses decode to none and are refused
    function automatic dpwm_pkg::dpwm_reg_t reg_decode(input logic [11:0] addr);
        dpwm_pkg::dpwm_reg_t r;
        r = dpwm_pkg::DPWM_REG_NONE;
        if (addr[1:0] == 2'h0) begin
            case (addr[11:2])
                `DPWM_IDX_CLK:  r = dpwm_pkg::DPWM_REG_CLK;
                `DPWM_IDX_POL:  r = dpwm_pkg::DPWM_REG_POL;
                `DPWM_IDX_SCAL: r = dpwm_pkg::DPWM_REG_SCAL;
                `DPWM_IDX_EN:   r = dpwm_pkg::DPWM_REG_EN;
                `DPWM_IDX_CNT1: r = dpwm_pkg::DPWM_REG_CNT1;
                `DPWM_IDX_CNT2: r = dpwm_pkg::DPWM_REG_CNT2;
                `DPWM_IDX_PER1: r = dpwm_pkg::DPWM_REG_PER1;
                `DPWM_IDX_PER2: r = dpwm_pkg::DPWM_REG_PER2;
                `DPWM_IDX_DTY1: r = dpwm_pkg::DPWM_REG_DTY1;
                `DPWM_IDX_DTY2: r = dpwm_pkg::DPWM_REG_DTY2;
                default:        r = dpwm_pkg::DPWM_REG_NONE;
            endcase
        end
        return r;
    endfunction

    // waveform level for a count against duty and period
    function automatic logic pwm_level(
        input logic [15:0] cnt,
        input logic [15:0] duty,
        input logic [15:0] per,
        input logic        pol
    );
        logic lvl;
        lvl = pol;
        // period zero, or duty at or past the period: constant start level
        // duty zero with a nonzero period: constant opposite level
        if ((per != 16'h0000) && (duty < per)) begin
            lvl = pol ^ (cnt >= duty);
        end
        return lvl;
    endfunction

    // bus decode and register file
    dpwm_pkg::dpwm_reg_t sel;
    logic                wr_en;
    logic                rd_setup;
    logic [7:0]          reg_clk;
    logic [7:0]          reg_pol;
    logic [7:0]          reg_scal;
    logic [7:0]          reg_en;
    logic [7:0]          per_buf [2];
    logic [7:0]          dty_buf [2];
    logic [7:0]          per_act [2];
    logic [7:0]          dty_act [2];
    logic [7:0]          cnt     [2];
    logic [1:0]          cnt_wr;
    // clock chain
    logic [6:0]          presc;
    logic [6:0]          a_mask;
    logic                tick_a;
    logic [7:0]          scnt;
    logic                shalf;
    logic                s_wrap;
    logic                tick_s;
    // channel terms
    logic                concat;
    logic [1:0]          tick;
    logic [1:0]          en_eff;
    logic [1:0]          roll;
    logic [1:0]          step;
    logic [1:0]          load;
    logic                roll16;
    logic [15:0]         cnt16;
    logic [15:0]         per16;
    logic [15:0]         dty16;
    logic [1:0]          next_pwm;
    logic [7:0]          next_rdata;

    // apb decode; the slave is always ready
    // pstrb[0] gates every write, since each register is one byte wide
    assign sel       = reg_decode(i_apb.paddr);
    assign o_pready  = 1'b1;
    assign o_pslverr = i_apb.psel & i_apb.penable & (sel == dpwm_pkg::DPWM_REG_NONE);
    assign wr_en     = i_apb.psel & i_apb.penable & i_apb.pwrite & i_apb.pstrb[0]
                       & (sel != dpwm_pkg::DPWM_REG_NONE);
    assign rd_setup  = i_apb.psel & ~i_apb.penable & ~i_apb.pwrite;

    // control register writes
    // unimplemented bits are never stored, so they read back as zero
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            reg_clk  <= `DPWM_RST_CTRL;
            reg_pol  <= `DPWM_RST_CTRL;
            reg_scal <= `DPWM_RST_CTRL;
            reg_en   <= `DPWM_RST_CTRL; // R11 R13
        end else if (wr_en) begin
            case (sel)
                dpwm_pkg::DPWM_REG_CLK:  reg_clk  <= i_apb.pwdata[7:0] & `DPWM_CLK_MASK;
                dpwm_pkg::DPWM_REG_POL:  reg_pol  <= i_apb.pwdata[7:0] & `DPWM_POL_MASK; // R10
                dpwm_pkg::DPWM_REG_SCAL: reg_scal <= i_apb.pwdata[7:0];
                dpwm_pkg::DPWM_REG_EN:   reg_en   <= i_apb.pwdata[7:0] & `DPWM_EN_MASK; // R11 R13
                default:                 reg_clk  <= reg_clk;
            endcase
        end
    end

    // period and duty buffers, written any time
    // the active copies load from these in the channel block
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            per_buf[0] <= `DPWM_RST_PER;
            per_buf[1] <= `DPWM_RST_PER;
            dty_buf[0] <= `DPWM_RST_DTY;
            dty_buf[1] <= `DPWM_RST_DTY;
        end else if (wr_en) begin
            case (sel)
                dpwm_pkg::DPWM_REG_PER1: per_buf[0] <= i_apb.pwdata[7:0];
                dpwm_pkg::DPWM_REG_PER2: per_buf[1] <= i_apb.pwdata[7:0];
                dpwm_pkg::DPWM_REG_DTY1: dty_buf[0] <= i_apb.pwdata[7:0];
                dpwm_pkg::DPWM_REG_DTY2: dty_buf[1] <= i_apb.pwdata[7:0];
                default:                 per_buf[0] <= per_buf[0];
            endcase
        end
    end

    // counter write strobes, any value
    assign cnt_wr[0] = wr_en & (sel == dpwm_pkg::DPWM_REG_CNT1); // R14
    assign cnt_wr[1] = wr_en & (sel == dpwm_pkg::DPWM_REG_CNT2); // R14

    // read mux, masked bits read zero
    always_comb begin
        case (sel)
            dpwm_pkg::DPWM_REG_CLK:  next_rdata = reg_clk & `DPWM_CLK_MASK; // R12
            dpwm_pkg::DPWM_REG_POL:  next_rdata = reg_pol & `DPWM_POL_MASK; // R12
            dpwm_pkg::DPWM_REG_SCAL: next_rdata = reg_scal;
            dpwm_pkg::DPWM_REG_EN:   next_rdata = reg_en & `DPWM_EN_MASK; // R12
            dpwm_pkg::DPWM_REG_CNT1: next_rdata = cnt[0];
            dpwm_pkg::DPWM_REG_CNT2: next_rdata = cnt[1];
            dpwm_pkg::DPWM_REG_PER1: next_rdata = per_buf[0];
            dpwm_pkg::DPWM_REG_PER2: next_rdata = per_buf[1];
            dpwm_pkg::DPWM_REG_DTY1: next_rdata = dty_buf[0];
            dpwm_pkg::DPWM_REG_DTY2: next_rdata = dty_buf[1];
            default:                 next_rdata = 8'h00;
        endcase
    end

    // read data captured in the setup cycle, held through access
    // a counter read shows the count as it stood in the setup cycle
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            o_prdata <= {24'h00_0000, next_rdata};
        end
    end

    // free-running prescaler for clock a
    // a code change takes effect at the next aligned tick
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            presc <= 7'h00;
        end else begin
            presc <= presc + 7'h01;
        end
    end

    // clock a tick every two to the code bus cycles
    assign a_mask = 7'((8'h01 << reg_clk[2:0]) - 8'h01); // R06
    assign tick_a = (presc & a_mask) == a_mask; // R06

    // scaled clock: scale value a-ticks per half, zero counts 256
    // a scale lowered below the running count wraps on the next tick, not after 256
    assign s_wrap = scnt >= (reg_scal - 8'h01); // R07
    assign tick_s = tick_a & s_wrap & shalf; // R07

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            scnt  <= 8'h00;
            shalf <= 1'b0;
        end else if (tick_a) begin
            if (s_wrap) begin
                scnt  <= 8'h00;
                shalf <= ~shalf; // R07
            end else begin
                scnt <= scnt + 8'h01;
            end
        end
    end

    // joined view: channel 1 high byte, channel 2 low byte
    assign concat = reg_clk[`DPWM_CLK_CONCAT]; // R03
    assign cnt16  = {cnt[0], cnt[1]};
    assign per16  = {per_act[0], per_act[1]};
    assign dty16  = {dty_act[0], dty_act[1]};
    assign roll16 = cnt16 == (per16 - 16'h0001); // R03

    // per-channel clock, enable, rollover and latch terms
    generate
        for (genvar i = 0; i < 2; i++) begin : g_chan
            logic csel;
            logic en_bit;
            logic clr;
            assign csel   = concat ? reg_pol[`DPWM_POL_CSEL2] : reg_pol[`DPWM_POL_CSEL1 + i]; // R03
            assign tick[i] = csel ? tick_s : tick_a; // R08
            assign en_bit = reg_en[`DPWM_EN_EN1 + i];
            assign en_eff[i] = concat ? reg_en[`DPWM_EN_EN2] : en_bit;
            assign roll[i] = concat ? roll16 : (cnt[i] == (per_act[i] - 8'h01)); // R15
            assign step[i] = (concat && (i == 0)) ? (cnt[1] == 8'hff) : 1'b1; // R03
            assign clr    = concat ? (|cnt_wr) : cnt_wr[i]; // R05 R14
            assign load[i] = clr | ~en_eff[i] | (tick[i] & roll[i]); // R04 R05

            // channel counter
            // a clear or a disabled channel wins over a pending tick
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    cnt[i] <= `DPWM_RST_CNT;
                end else if (clr || !en_eff[i]) begin
                    cnt[i] <= 8'h00; // R14 R17
                end else if (tick[i]) begin
                    if (roll[i]) begin
                        cnt[i] <= 8'h00; // R15
                    end else if (step[i]) begin
                        cnt[i] <= cnt[i] + 8'h01; // R01
                    end
                end
            end

            // active period and duty, double buffered
            // a disabled channel keeps its active copies equal to the buffers
            always_ff @(posedge i_clk) begin
                if (i_reset) begin
                    per_act[i] <= `DPWM_RST_PER;
                    dty_act[i] <= `DPWM_RST_DTY;
                end else if (load[i]) begin
                    per_act[i] <= per_buf[i]; // R04 R05 R15
                    dty_act[i] <= dty_buf[i]; // R04 R05 R15
                end
            end
        end
    endgenerate

    // output levels, boundary cases folded into pwm_level
    // when joined, channel one's pin rests at its polarity bit
    always_comb begin
        next_pwm[0] = reg_pol[`DPWM_POL_POL1]; // R17
        next_pwm[1] = reg_pol[`DPWM_POL_POL2]; // R17
        if (concat) begin
            if (en_eff[1]) begin
                next_pwm[1] = pwm_level(cnt16, dty16, per16, reg_pol[`DPWM_POL_POL2]); // R03 R16
            end
        end else begin
            if (en_eff[0]) begin
                next_pwm[0] = pwm_level({8'h00, cnt[0]}, {8'h00, dty_act[0]}, {8'h00, per_act[0]},
                                        reg_pol[`DPWM_POL_POL1]); // R02 R09 R16
            end
            if (en_eff[1]) begin
                next_pwm[1] = pwm_level({8'h00, cnt[1]}, {8'h00, dty_act[1]}, {8'h00, per_act[1]},
                                        reg_pol[`DPWM_POL_POL2]); // R02 R09 R16
            end
        end
    end

    // registered pin drive
    // a flop here keeps decode changes from glitching the pins
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_pwm <= 2'b00;
        end else begin
            o_pwm <= next_pwm; // R01
        end
    end

endmodule

//--- verilog/dpwm_defines.svh
// dpwm register map, field positions and reset values
// assumes word-aligned apb access, register index times four is the byte address
`ifndef DPWM_DEFINES_SVH
`define DPWM_DEFINES_SVH

// register indices
`define DPWM_IDX_CLK        10'h060
`define DPWM_IDX_POL        10'h061
`define DPWM_IDX_SCAL       10'h062
`define DPWM_IDX_EN         10'h063
`define DPWM_IDX_CNT1       10'h066
`define DPWM_IDX_CNT2       10'h067
`define DPWM_IDX_PER1       10'h06a
`define DPWM_IDX_PER2       10'h06b
`define DPWM_IDX_DTY1       10'h06e
`define DPWM_IDX_DTY2       10'h06f

// implemented bit masks, other bits read zero
`define DPWM_CLK_MASK       8'h47
`define DPWM_POL_MASK       8'h33
`define DPWM_EN_MASK        8'hc3

// field positions
`define DPWM_CLK_CONCAT     6
`define DPWM_POL_CSEL1      4
`define DPWM_POL_CSEL2      5
`define DPWM_POL_POL1       0
`define DPWM_POL_POL2       1
`define DPWM_EN_EN1         0
`define DPWM_EN_EN2         1
`define DPWM_EN_SCTEST      7
`define DPWM_EN_DISCMP      6

// reset values
`define DPWM_RST_CTRL       8'h00
`define DPWM_RST_CNT        8'h00
`define DPWM_RST_PER        8'hff
`define DPWM_RST_DTY        8'hff

`endif

//--- verilog/dpwm_pkg.sv
// dpwm types shared by the timer and its bench
// assumes an apb master on the same clock
package dpwm_pkg;

    // apb request carried as one bundle
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } dpwm_apb_req_t;

    // decoded register selector
    typedef enum logic [3:0] {
        DPWM_REG_NONE = 4'b0000,
        DPWM_REG_CLK  = 4'b0001,
        DPWM_REG_POL  = 4'b0010,
        DPWM_REG_SCAL = 4'b0011,
        DPWM_REG_EN   = 4'b0100,
        DPWM_REG_CNT1 = 4'b0101,
        DPWM_REG_CNT2 = 4'b0110,
        DPWM_REG_PER1 = 4'b0111,
        DPWM_REG_PER2 = 4'b1000,
        DPWM_REG_DTY1 = 4'b1001,
        DPWM_REG_DTY2 = 4'b1010
    } dpwm_reg_t;

endpackage

//--- verification/dpwm_timer_properties.sv
// port checker for the dual pwm timer
// assumes the zero-wait apb slave that it is bound to
`timescale 1ns/1ps
`include "dpwm_defines.svh"
module dpwm_props (
    input wire logic                    i_clk,
    input wire logic                    i_reset,
    input wire dpwm_pkg::dpwm_apb_req_t i_apb,
    input wire logic [31:0]             o_prdata,
    input wire logic                    o_pready,
    input wire logic                    o_pslverr,
    input wire logic [1:0]              o_pwm
);
    logic [1:0] pol_q;
    logic [1:0] en_q;
    logic       wr;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // write strobe as the slave takes it
    assign wr = i_apb.psel && i_apb.penable && i_apb.pwrite && i_apb.pstrb[0];
    // shadows of the polarity and enable bits
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            pol_q <= 2'b00;
            en_q  <= 2'b00;
        end else if (wr && i_apb.paddr == {`DPWM_IDX_POL, 2'b00}) begin
            pol_q <= i_apb.pwdata[1:0];
        end else if (wr && i_apb.paddr == {`DPWM_IDX_EN, 2'b00}) begin
            en_q <= i_apb.pwdata[1:0];
        end
    end
    sequence s_acc;
        i_apb.psel && i_apb.penable;
    endsequence
    sequence s_rd(a);
        i_apb.psel && i_apb.penable && !i_apb.pwrite && i_apb.paddr == a;
    endsequence
    property p_rst;
        disable iff (1'b0) i_reset |=> o_pwm == 2'b00;
    endproperty
    property p_idle;
        $stable(pol_q) |-> ((o_pwm ^ pol_q) & ~en_q & ~$past(en_q)) == 2'b00;
    endproperty
    property p_pol_rd;
        s_rd({`DPWM_IDX_POL, 2'b00}) |-> (o_prdata[7:0] & 8'hcc) == 8'h00;
    endproperty
    property p_en_rd;
        s_rd({`DPWM_IDX_EN, 2'b00}) |-> (o_prdata[7:0] & 8'h3c) == 8'h00;
    endproperty
    property p_clk_rd;
        s_rd({`DPWM_IDX_CLK, 2'b00}) |-> (o_prdata[7:0] & 8'hb8) == 8'h00;
    endproperty
    property p_hi;
        s_acc ##0 !i_apb.pwrite |-> o_prdata[31:8] == 24'h000000;
    endproperty
    property p_ready;
        s_acc |-> o_pready;
    endproperty
    property p_err;
        s_acc ##0 i_apb.paddr == {10'h064, 2'b00} |-> o_pslverr && (i_apb.pwrite || o_prdata == 32'h00000000);
    endproperty
    property p_wr_ok;
        wr && i_apb.paddr == {`DPWM_IDX_POL, 2'b00} |-> !o_pslverr;
    endproperty
    a_rst: assert property (p_rst)
        else $error("pins not low after reset");
    a_idle: assert property (p_idle)
        else $error("disabled pin not at polarity level");
    a_pol_rd: assert property (p_pol_rd)
        else $error("polarity read shows unused bits");
    a_en_rd: assert property (p_en_rd)
        else $error("enable read shows unused bits");
    a_clk_rd: assert property (p_clk_rd)
        else $error("prescale read shows unused bits");
    a_hi: assert property (p_hi)
        else $error("read data above bit 7 not zero");
    a_ready: assert property (p_ready)
        else $error("access not answered at once");
    a_wr_ok: assert property (p_wr_ok)
        else $error("polarity write refused");
    a_err: assert property (p_err)
        else $error("unmapped access not refused");
endmodule
bind dpwm_timer dpwm_props i_dpwm_props (.i_clk(i_clk), .i_reset(i_reset), .i_apb(i_apb),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_pwm(o_pwm));

//--- verification/dpwm_load.sv
// load model on one pwm pin: counts high cycles and rising edges
// assumes the pin is sampled on the bus clock
`timescale 1ns/1ps
module dpwm_load (
    input  wire logic        i_clk,
    input  wire logic        i_clear,
    input  wire logic        i_pin,
    output logic      [15:0] o_high,
    output logic      [15:0] o_rise
);
    logic prev;
    // counters restart on clear
    always @(posedge i_clk) begin
        prev <= i_pin;
        if (i_clear) begin
            o_high <= 16'h0000;
            o_rise <= 16'h0000;
        end else begin
            o_high <= o_high + {15'h0000, i_pin};
            o_rise <= o_rise + {15'h0000, i_pin & ~prev};
        end
    end
endmodule

//--- verification/dpwm_timer_test.sv
// bench for the dual pwm timer: apb tasks, pin loads on both outputs
// assumes a zero-wait slave on a 50 ns clock
`timescale 1ns/1ps
`include "dpwm_defines.svh"
module dpwm_timer_test;
    logic                    i_clk;
    logic                    i_reset;
    dpwm_pkg::dpwm_apb_req_t req;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
    logic [1:0]              pwm;
    logic                    clr;
    logic [15:0]             hi [2];
    logic [15:0]             ri [2];
    logic [31:0]             q;
    logic                    e;
    int                      n_fail;
    int                      check_count;
    int                      k;
    dpwm_timer i_dpwm_timer (.i_clk(i_clk), .i_reset(i_reset), .i_apb(req), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_pwm(pwm));
    dpwm_load i_dpwm_load (.i_clk(i_clk), .i_clear(clr), .i_pin(pwm[0]), .o_high(hi[0]), .o_rise(ri[0]));
    dpwm_load i_dpwm_load_2 (.i_clk(i_clk), .i_clear(clr), .i_pin(pwm[1]), .o_high(hi[1]), .o_rise(ri[1]));
    // bus clock
    initial i_clk = 1'b0;
    always #25 i_clk = ~i_clk;
    task automatic summarize();
        if (n_fail == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task automatic xfer(input logic w, input logic [9:0] idx, input logic [1:0] lo, input logic [7:0] d);
        int n;
        req <= '{1'b1, 1'b0, w, {idx, lo}, {24'h000000, d}, 4'hf};
        @(posedge i_clk);
        req.penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge i_clk);
            if (pready === 1'b1) break;
        end
        if (n == 16) begin
            n_fail++;
            summarize();
        end
        q = prdata;
        e = pslverr;
        req <= '0;
        @(posedge i_clk);
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, 2'b00, d);
    endtask
    task automatic rd(input logic [9:0] idx, input logic [7:0] x);
        xfer(1'b0, idx, 2'b00, 8'h00);
        chk(q, {24'h000000, x});
    endtask
    // count a pin over a window and compare high cycles and rising edges
    task automatic meas(input int ch, input int win, input logic [15:0] eh, input logic [15:0] er);
        clr <= 1'b1;
        @(posedge i_clk);
        clr <= 1'b0;
        repeat (win) @(posedge i_clk);
        @(negedge i_clk);
        chk({16'h0000, hi[ch]}, {16'h0000, eh});
        chk({16'h0000, ri[ch]}, {16'h0000, er});
        @(posedge i_clk);
    endtask
    // program channel one, restart its counter, then measure
    task automatic run1(input logic [7:0] pol, input logic [7:0] per, input logic [7:0] dty,
                        input int win, input logic [15:0] eh, input logic [15:0] er);
        wr(`DPWM_IDX_POL, pol);
        wr(`DPWM_IDX_PER1, per);
        wr(`DPWM_IDX_DTY1, dty);
        wr(`DPWM_IDX_EN, 8'h01);
        wr(`DPWM_IDX_CNT1, 8'h5a);
        meas(0, win, eh, er);
    endtask
    // main sequence
    initial begin
        i_reset = 1'b1;
        req = '0;
        clr = 1'b0;
        n_fail = 0;
        check_count = 0;
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        rd(`DPWM_IDX_CLK, 8'h00);
        rd(`DPWM_IDX_SCAL, 8'h00);
        rd(`DPWM_IDX_EN, 8'h00);
        rd(`DPWM_IDX_CNT2, 8'h00);
        rd(`DPWM_IDX_PER2, 8'hff);
        wr(`DPWM_IDX_CLK, 8'hff);
        rd(`DPWM_IDX_CLK, 8'h47);
        wr(`DPWM_IDX_POL, 8'hff);
        rd(`DPWM_IDX_POL, 8'h33);
        wr(`DPWM_IDX_EN, 8'hff);
        rd(`DPWM_IDX_EN, 8'hc3);
        wr(`DPWM_IDX_SCAL, 8'ha5);
        rd(`DPWM_IDX_SCAL, 8'ha5);
        wr(`DPWM_IDX_EN, 8'h00);
        wr(`DPWM_IDX_CLK, 8'h00);
        xfer(1'b0, 10'h064, 2'b00, 8'h00);
        chk({31'h0, e}, 32'h00000001);
        chk(q, 32'h00000000);
        run1(8'h00, 8'h04, 8'h01, 40, 16'h001e, 16'h000a);
        run1(8'h01, 8'h04, 8'h01, 40, 16'h000a, 16'h000a);
        run1(8'h00, 8'h04, 8'h00, 40, 16'h0028, 16'h0000);
        run1(8'h01, 8'h04, 8'h00, 40, 16'h0000, 16'h0000);
        run1(8'h00, 8'h04, 8'h04, 40, 16'h0000, 16'h0000);
        run1(8'h01, 8'h04, 8'h05, 40, 16'h0028, 16'h0000);
        run1(8'h01, 8'h00, 8'h02, 40, 16'h0028, 16'h0000);
        run1(8'h00, 8'h00, 8'h02, 40, 16'h0000, 16'h0000);
        run1(8'h00, 8'hc8, 8'h64, 8, 16'h0000, 16'h0000);
        wr(`DPWM_IDX_DTY1, 8'h01);
        meas(0, 40, 16'h0000, 16'h0000);
        rd(`DPWM_IDX_DTY1, 8'h01);
        for (k = 0; k < 8; k++) begin
            wr(`DPWM_IDX_CLK, k[7:0]);
            run1(8'h00, 8'h02, 8'h01, 512, 16'h0100, 16'h0100 >> k);
        end
        wr(`DPWM_IDX_CLK, 8'h00);
        wr(`DPWM_IDX_SCAL, 8'h03);
        run1(8'h10, 8'h02, 8'h01, 480, 16'h00f0, 16'h0028);
        wr(`DPWM_IDX_SCAL, 8'h00);
        run1(8'h10, 8'h02, 8'h01, 2048, 16'h0400, 16'h0002);
        wr(`DPWM_IDX_EN, 8'h00);
        wr(`DPWM_IDX_CLK, 8'h40);
        wr(`DPWM_IDX_POL, 8'h00);
        wr(`DPWM_IDX_PER1, 8'h01);
        wr(`DPWM_IDX_PER2, 8'h00);
        wr(`DPWM_IDX_DTY1, 8'h00);
        wr(`DPWM_IDX_DTY2, 8'h80);
        wr(`DPWM_IDX_EN, 8'h02);
        wr(`DPWM_IDX_CNT2, 8'h00);
        meas(1, 512, 16'h0100, 16'h0002);
        wr(`DPWM_IDX_CLK, 8'h00);
        wr(`DPWM_IDX_SCAL, 8'h01);
        wr(`DPWM_IDX_POL, 8'h22);
        wr(`DPWM_IDX_PER2, 8'h04);
        wr(`DPWM_IDX_DTY2, 8'h01);
        wr(`DPWM_IDX_EN, 8'h02);
        wr(`DPWM_IDX_CNT2, 8'h00);
        meas(1, 40, 16'h000a, 16'h0005);
        wr(`DPWM_IDX_EN, 8'h00);
        wr(`DPWM_IDX_POL, 8'h01);
        meas(0, 40, 16'h0028, 16'h0000);
        summarize();
    end
endmodule
